// File: common/gpd_regs.svh
// Pointer map, field positions, reset values and timing of the gamma pointer decoder.
// Included by the package users; definitions only.
`ifndef GPD_REGS_SVH
`define GPD_REGS_SVH

// ==========================================================
// Pointer addresses (full eight-bit pointer byte)
`define GPD_PTR_COMMON 8'h12
`define GPD_PTR_GAIN 8'h1C
`define GPD_PTR_HI_CLAMP 8'h1E
`define GPD_PTR_LO_CLAMP 8'h1F
`define GPD_PTR_REVISION 8'h3C
`define GPD_PTR_IDENT 8'h3D
`define GPD_PTR_RAW 8'h3E
`define GPD_PTR_BANK_CNT 8'h3F

// ==========================================================
// Fields
`define GPD_CTL_HI_BIT 7
`define GPD_CTL_LO_BIT 6
`define GPD_GAIN_TAG 8'h80
`define GPD_NO_INDEX 4'hF
`define GPD_IDX_COMMON 4'h8
`define GPD_IDX_HI 4'h9
`define GPD_IDX_LO 4'hA
`define GPD_NUM_LEVELS 11
`define GPD_LAST_DAC 4'h8

// ==========================================================
// Reset values
`define GPD_GAIN_RST 8'h01
`define GPD_DAC_RST 10'h000
`define GPD_COMMON_RST 10'h200
`define GPD_HI_RST 10'h3FF
`define GPD_LO_RST 10'h000

// ==========================================================
// Timing
`define GPD_INIT_TIME_NS 1200000
`define GPD_CLK_PERIOD_NS 8

`endif

// File: common/gpd_pkg.sv
// Types shared by the gamma pointer decoder modules.
// Assumes nothing of its surroundings.
package gpd_pkg;
    typedef enum logic [2:0] {
        GPD_IDLE = 3'b000,
        GPD_ADDR = 3'b001,
        GPD_ADDR_ACK = 3'b010,
        GPD_RX = 3'b011,
        GPD_RX_ACK = 3'b100,
        GPD_TX = 3'b101,
        GPD_TX_ACK = 3'b110
    } gpd_state_e;

    // Pointer control field as {high, low}
    typedef enum logic [1:0] {
        GPD_OP_ACCESS = 2'b00,
        GPD_OP_GENERAL = 2'b01,
        GPD_OP_SINGLE = 2'b10,
        GPD_OP_BAD = 2'b11
    } gpd_op_e;

    typedef logic [9:0] gpd_level_t;
endpackage

// File: core/gpd_init_timer.sv
// Power-on initialisation timer: ready rises once the gain register may be trusted.
// Assumes a synchronised active-low reset and a clock enable from the top.
`timescale 1ns/1ps
module gpd_init_timer #(
    parameter int CYCLES = 150000
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Status
    output logic ready_out
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            ready_out <= 1'b0;
        end else if (clk_en_in && !ready_out) begin
            cnt_q <= cnt_q + W'(1);
            ready_out <= (cnt_q == W'(CYCLES - 1)); // R8
        end
    end

    chk_init_delay: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R8
        $rose(ready_out) |-> $past(cnt_q) == W'(CYCLES - 1))
        else $error("ready rose before the init time");
endmodule

// File: core/gpd_gain_switch.sv
// Turns the one-hot gain word into the eight feedback switch controls.
// Assumes gain_in is one-hot; a word that is not leaves the switches as they were.
`timescale 1ns/1ps
module gpd_gain_switch (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    // Gain
    input wire logic [7:0] gain_in,
    input wire logic ready_in,
    // Switches, bit k closes position k+1
    output logic [7:0] switch_out,
    output logic inverting_out
);
    // Unity sits on position 8 and the external resistor on position 1, so the map is a bit reversal
    function automatic logic [7:0] reverse8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[7-i] = v[i];
        end
        return r;
    endfunction

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            switch_out <= 8'h00;
            inverting_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!ready_in) begin
                switch_out <= 8'h00;
                inverting_out <= 1'b0;
            end else if ($onehot(gain_in)) begin // R15
                switch_out <= reverse8(gain_in); // R10 R14
                inverting_out <= |gain_in[6:1]; // R11
            end
        end
    end

    chk_one_switch: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R10
        ready_in && $onehot(gain_in) |=> $onehot(switch_out))
        else $error("not exactly one switch closed");
    chk_buffer_pos: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
        clk_en_in && ready_in && gain_in == 8'h01 |=> switch_out == 8'h80)
        else $error("unity gain not on position 8");
    chk_ext_pos: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R14
        clk_en_in && ready_in && gain_in == 8'h80 |=> switch_out == 8'h01 && !inverting_out)
        else $error("external gain not on position 1");
    chk_invert_pos: assert property (@(posedge clock_in) disable iff (!rst_n_in) // R11
        inverting_out == (|switch_out[6:1]))
        else $error("inverting flag disagrees with switch position");
endmodule

// File: core/gpd_pointer_decode.sv
// Two-wire slave, pointer decoder, acquire sequencer and level/gain registers.
// Assumes scl/sda are synchronous to clock_in and much slower than it; sda is open drain.
// The nonvolatile store answers nv_data_in combinationally for nv_addr_out.
`timescale 1ns/1ps
`include "gpd_regs.svh"

// Functional notes
// [R1] Control 00: write or read addressed DAC
// [R2] Control 01: load pointed DAC from memory; the code loads all DACs for 01 and the pointed DAC for 10
// [R3] Control 10: load all DACs; 11 forbidden; the code loads the pointed DAC for 10 and all DACs for 01
// [R4] Master puts control bits above address
// [R5] Special read-only pointers need exact byte
// [R6] Eight gain configurations chosen over bus
// [R7] Gain register at 1Ch holds 8 bits
// [R8] Gain resets to unity, valid after 1.2ms
// [R9] Gain one-hot B0..B7, B15 set
// [R10] Exactly one of eight switches closed
// [R11] Positions 2..7 give inverting gain
// [R12] Plain access clears D7 and D6
// [R13] Unused pointers read as zero
// [R14] Unity uses position 8, external position 1
// [R15] Non one-hot gain write keeps switches
module gpd_pointer_decode #(
    parameter logic [6:0] DEV_ADDR = 7'h4A, // Arbitrary bus address
    parameter logic [15:0] REVISION = 16'h0001, // Arbitrary value
    parameter logic [15:0] IDENT = 16'h00A5, // Arbitrary value
    parameter int INIT_CYCLES = (`GPD_INIT_TIME_NS + `GPD_CLK_PERIOD_NS - 1) / `GPD_CLK_PERIOD_NS
) (
    // Clock, reset, enable
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic clk_en_in,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n_out,
    // Nonvolatile store
    output logic [3:0] nv_addr_out,
    input wire logic [9:0] nv_data_in,
    input wire logic [15:0] bank_count_in,
    // Analog controls
    output logic [`GPD_NUM_LEVELS*10-1:0] level_out,
    output logic [7:0] gain_out,
    output logic [7:0] switch_out,
    output logic inverting_out,
    output logic gain_valid_out
);
    // ==========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ==========================================================
    // Bus line sampling and conditions
    logic scl_q;
    logic sda_q;
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (clk_en_in) begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    logic bus_start;
    logic bus_stop;
    logic scl_rise;
    logic scl_fall;
    assign bus_start = scl_q && scl_p_q && sda_p_q && !sda_q;
    assign bus_stop = scl_q && scl_p_q && !sda_p_q && sda_q;
    assign scl_rise = scl_q && !scl_p_q;
    assign scl_fall = !scl_q && scl_p_q;

    // ==========================================================
    // Register storage and decode
    gpd_pkg::gpd_level_t [`GPD_NUM_LEVELS-1:0] level_q;
    logic [7:0] gain_q;
    logic [9:0] raw_q;
    logic [7:0] ptr_q;

    // Storage slot of a pointer; full byte compare keeps control bits out of it
    function automatic logic [3:0] reg_index(input logic [7:0] p);
        logic [3:0] i;
        i = `GPD_NO_INDEX;
        if (p[7:3] == 5'h00) begin
            i = {1'b0, p[2:0]};
        end else if (p == `GPD_PTR_COMMON) begin
            i = `GPD_IDX_COMMON;
        end else if (p == `GPD_PTR_HI_CLAMP) begin
            i = `GPD_IDX_HI;
        end else if (p == `GPD_PTR_LO_CLAMP) begin
            i = `GPD_IDX_LO;
        end
        return i;
    endfunction

    function automatic logic [15:0] rd_word(input logic [7:0] p);
        logic [3:0] i;
        logic [15:0] w;
        i = reg_index(p);
        w = 16'h0000; // R13
        case (p)
            `GPD_PTR_REVISION: w = REVISION; // R5
            `GPD_PTR_IDENT: w = IDENT;
            `GPD_PTR_RAW: w = {6'h00, raw_q};
            `GPD_PTR_BANK_CNT: w = bank_count_in;
            `GPD_PTR_GAIN: w = {`GPD_GAIN_TAG, gain_q}; // R9
            default: begin
                if (i != `GPD_NO_INDEX) begin
                    w = {6'h00, level_q[i]}; // R1
                end
            end
        endcase
        return w;
    endfunction

    // ==========================================================
    // Byte engine
    gpd_pkg::gpd_state_e st_q;
    logic [7:0] sr_q;
    logic [3:0] bit_q;
    logic rw_q;
    logic lsb_q;
    logic nack_q;
    logic [15:0] hold_q;
    logic [1:0] byte_idx_q;
    logic [7:0] msb_q;

    logic rx_done;
    logic tx_next;
    logic [7:0] ptr_next;
    logic [15:0] rd_cur;
    logic [15:0] rd_nxt;
    assign rx_done = clk_en_in && st_q == gpd_pkg::GPD_RX && scl_fall && bit_q == 4'h8;
    assign tx_next = clk_en_in && st_q == gpd_pkg::GPD_TX_ACK && scl_fall && !nack_q && lsb_q;
    // Sequential access steps only the address field
    assign ptr_next = {ptr_q[7:6], ptr_q[5:0] + 6'h01};
    // A process rather than an assign, so the words follow every stored value the function reads
    always_comb begin
        rd_cur = rd_word(ptr_q);
        rd_nxt = rd_word(ptr_next);
    end

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= gpd_pkg::GPD_IDLE;
            sr_q <= 8'h00;
            bit_q <= 4'h0;
            rw_q <= 1'b0;
            lsb_q <= 1'b0;
            nack_q <= 1'b0;
            hold_q <= 16'h0000;
            sda_oe_n_out <= 1'b1;
        end else if (clk_en_in) begin
            if (bus_start) begin
                st_q <= gpd_pkg::GPD_ADDR;
                bit_q <= 4'h0;
                sda_oe_n_out <= 1'b1;
            end else if (bus_stop) begin
                st_q <= gpd_pkg::GPD_IDLE;
                sda_oe_n_out <= 1'b1;
            end else begin
                case (st_q)
                    gpd_pkg::GPD_ADDR, gpd_pkg::GPD_RX: begin
                        if (scl_rise) begin
                            sr_q <= {sr_q[6:0], sda_q};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            if (st_q == gpd_pkg::GPD_RX) begin
                                st_q <= gpd_pkg::GPD_RX_ACK;
                                sda_oe_n_out <= 1'b0;
                            end else if (sr_q[7:1] == DEV_ADDR) begin
                                st_q <= gpd_pkg::GPD_ADDR_ACK;
                                rw_q <= sr_q[0];
                                sda_oe_n_out <= 1'b0;
                            end else begin
                                st_q <= gpd_pkg::GPD_IDLE;
                            end
                        end
                    end
                    gpd_pkg::GPD_ADDR_ACK, gpd_pkg::GPD_RX_ACK: begin
                        if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (st_q == gpd_pkg::GPD_ADDR_ACK && rw_q) begin
                                st_q <= gpd_pkg::GPD_TX;
                                hold_q <= rd_cur;
                                sr_q <= rd_cur[15:8];
                                sda_oe_n_out <= rd_cur[15];
                                lsb_q <= 1'b0;
                            end else begin
                                st_q <= gpd_pkg::GPD_RX;
                                sda_oe_n_out <= 1'b1;
                            end
                        end
                    end
                    gpd_pkg::GPD_TX: begin
                        if (scl_fall) begin
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7) begin
                                st_q <= gpd_pkg::GPD_TX_ACK;
                                sda_oe_n_out <= 1'b1;
                            end else begin
                                sr_q <= {sr_q[6:0], 1'b0};
                                sda_oe_n_out <= sr_q[6];
                            end
                        end
                    end
                    gpd_pkg::GPD_TX_ACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_q;
                        end else if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (nack_q) begin
                                st_q <= gpd_pkg::GPD_IDLE;
                            end else if (!lsb_q) begin
                                st_q <= gpd_pkg::GPD_TX;
                                sr_q <= hold_q[7:0];
                                sda_oe_n_out <= hold_q[7];
                                lsb_q <= 1'b1;
                            end else begin
                                st_q <= gpd_pkg::GPD_TX;
                                hold_q <= rd_nxt;
                                sr_q <= rd_nxt[15:8];
                                sda_oe_n_out <= rd_nxt[15];
                                lsb_q <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        st_q <= gpd_pkg::GPD_IDLE;
                    end
                endcase
            end
        end
    end

    // Open drain: the line is only ever pulled low
    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ==========================================================
    // Pointer and data byte sequencing
    gpd_pkg::gpd_op_e op;
    logic wr_commit;
    logic [15:0] wr_word;
    logic acq_start;
    assign op = gpd_pkg::gpd_op_e'(sr_q[`GPD_CTL_HI_BIT:`GPD_CTL_LO_BIT]); // R4
    assign wr_commit = rx_done && byte_idx_q == 2'h2;
    assign wr_word = {msb_q, sr_q};
    assign acq_start = rx_done && byte_idx_q == 2'h0;

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ptr_q <= 8'h00;
            byte_idx_q <= 2'h0;
            msb_q <= 8'h00;
        end else if (clk_en_in) begin
            if (bus_start) begin
                byte_idx_q <= 2'h0;
            end else if (rx_done) begin
                case (byte_idx_q)
                    2'h0: begin
                        ptr_q <= sr_q;
                        byte_idx_q <= 2'h1;
                    end
                    2'h1: begin
                        msb_q <= sr_q;
                        byte_idx_q <= 2'h2;
                    end
                    default: begin
                        ptr_q <= ptr_next;
                        byte_idx_q <= 2'h1;
                    end
                endcase
            end else if (tx_next) begin
                ptr_q <= ptr_next;
            end
        end
    end

    // ==========================================================
    // Acquire sequencer: one nonvolatile word per cycle
    logic acq_busy_q;
    logic [3:0] acq_end_q;
    logic [3:0] acq_idx;
    assign acq_idx = reg_index({2'h0, sr_q[5:0]});

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acq_busy_q <= 1'b0;
            acq_end_q <= 4'h0;
            nv_addr_out <= 4'h0;
        end else if (clk_en_in) begin
            if (acq_start && op == gpd_pkg::GPD_OP_SINGLE && acq_idx <= `GPD_LAST_DAC) begin
                acq_busy_q <= 1'b1; // R2
                nv_addr_out <= acq_idx;
                acq_end_q <= acq_idx;
            end else if (acq_start && op == gpd_pkg::GPD_OP_GENERAL) begin
                acq_busy_q <= 1'b1; // R3
                nv_addr_out <= 4'h0;
                acq_end_q <= `GPD_LAST_DAC;
            end else if (acq_busy_q) begin
                acq_busy_q <= nv_addr_out != acq_end_q;
                nv_addr_out <= nv_addr_out + 4'h1;
            end
        end
    end

    // ==========================================================
    // Level and gain registers
    logic [3:0] wr_idx;
    assign wr_idx = reg_index(ptr_q);

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < `GPD_NUM_LEVELS; i++) begin
                level_q[i] <= `GPD_DAC_RST;
            end
            level_q[`GPD_IDX_COMMON] <= `GPD_COMMON_RST;
            level_q[`GPD_IDX_HI] <= `GPD_HI_RST;
            level_q[`GPD_IDX_LO] <= `GPD_LO_RST;
            raw_q <= 10'h000;
        end else if (clk_en_in) begin
            if (acq_busy_q) begin
                level_q[nv_addr_out] <= nv_data_in; // R2 R3
                raw_q <= nv_data_in;
            end
            // Bus write comes last so it wins over a load still running
            if (wr_commit && wr_idx != `GPD_NO_INDEX) begin
                level_q[wr_idx] <= wr_word[9:0]; // R1
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            gain_q <= `GPD_GAIN_RST; // R8
        end else if (clk_en_in) begin
            if (wr_commit && ptr_q == `GPD_PTR_GAIN && $onehot(wr_word[7:0])) begin
                gain_q <= wr_word[7:0]; // R6 R7 R9 R15
            end
        end
    end

    assign level_out = level_q;
    assign gain_out = gain_q;

    // ==========================================================
    // Gain path
    gpd_init_timer #(
        .CYCLES(INIT_CYCLES)
    ) u_timer (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .clk_en_in(clk_en_in),
        .ready_out(gain_valid_out)
    );

    gpd_gain_switch u_switch (
        .clock_in(clock_in),
        .rst_n_in(rst_n_q),
        .clk_en_in(clk_en_in),
        .gain_in(gain_q),
        .ready_in(gain_valid_out),
        .switch_out(switch_out),
        .inverting_out(inverting_out)
    );

    // ==========================================================
    // Checks (assume clk_en_in held high)
    chk_dac_write: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R1
        wr_commit && ptr_q[7:3] == 5'h00 |=> level_q[$past(ptr_q[2:0])] == $past(wr_word[9:0]))
        else $error("DAC write not stored");
    chk_single_acq: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R2
        acq_start && op == gpd_pkg::GPD_OP_SINGLE && sr_q[5:3] == 3'h0
        |=> acq_busy_q && nv_addr_out == $past(sr_q[3:0]) ##1 !acq_busy_q)
        else $error("single acquire did not load one word");
    chk_general_acq: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R3
        acq_start && op == gpd_pkg::GPD_OP_GENERAL |=> acq_busy_q[*8] ##1 acq_busy_q ##1 !acq_busy_q)
        else $error("general acquire did not load nine words");
    chk_bad_op: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R3
        acq_start && op == gpd_pkg::GPD_OP_BAD && !acq_busy_q |=> !acq_busy_q)
        else $error("forbidden control bits started a load");
    chk_ro_fixed: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R5
        wr_commit && ptr_q[7:2] == 6'h0F |=> $stable(gain_q) && $stable(level_q))
        else $error("read-only pointer was written");
    chk_gain_keep: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R15
        wr_commit && ptr_q == `GPD_PTR_GAIN && !$onehot(wr_word[7:0]) |=> $stable(gain_q))
        else $error("bad gain word accepted");
    chk_gain_store: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R7
        wr_commit && ptr_q == `GPD_PTR_GAIN && $onehot(wr_word[7:0]) |=> gain_q == $past(wr_word[7:0]))
        else $error("gain write not stored");
    chk_gain_read: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R9
        ptr_q == `GPD_PTR_GAIN |-> rd_cur[15] && rd_cur[7:0] == gain_q)
        else $error("gain read word malformed");
    chk_unused_zero: assert property (@(posedge clock_in) disable iff (!rst_n_q) // R13
        (ptr_q >= 8'h08 && ptr_q <= 8'h11) || (ptr_q >= 8'h13 && ptr_q <= 8'h17) |-> rd_cur == 16'h0000)
        else $error("unused pointer read not zero");
    chk_gain_reset: assert property (@(posedge clock_in) // R8
        $rose(rst_n_q) |-> gain_q == `GPD_GAIN_RST && !gain_valid_out)
        else $error("gain reset value wrong");

    cov_single: cover property (@(posedge clock_in) acq_start && op == gpd_pkg::GPD_OP_SINGLE);
    cov_general: cover property (@(posedge clock_in) acq_start && op == gpd_pkg::GPD_OP_GENERAL);
    cov_gain_write: cover property (@(posedge clock_in) wr_commit && ptr_q == `GPD_PTR_GAIN);
    cov_read: cover property (@(posedge clock_in) st_q == gpd_pkg::GPD_TX_ACK && tx_next);
endmodule

// File: verif/gpd_master_model.sv
// Two-wire bus master model: word write, word read, bare pointer.
// Assumes a pulled-up open-drain data wire and calls made just after a clock edge.
`timescale 1ns/1ps
module gpd_master_model (
    // Clock and slave drive
    input wire logic clock_in,
    input wire logic sda_oe_n_in,
    // Wire levels
    output logic scl_out,
    output logic sda_out
);
    logic drv = 1'b1;
    logic [17:0] r;
    assign sda_out = drv & sda_oe_n_in;
    initial scl_out = 1'b1;
    // Phases of four clocks, two above the minimum; start for a=1 b=0, stop for a=0 b=1
    // One phase, ending just after a rising edge so the lines never move on a sampling edge
    task automatic phase();
        repeat (4) @(posedge clock_in);
        #1;
    endtask
    task automatic cond(input logic a, input logic b);
        drv = a;
        phase();
        scl_out = 1'b1;
        phase();
        drv = b;
        phase();
        scl_out = b;
    endtask
    task automatic xfer(input logic [8:0] d);
        for (int i = 8; i >= 0; i--) begin
            drv = d[i];
            phase();
            scl_out = 1'b1;
            phase();
            r = {r[16:0], sda_out};
            scl_out = 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic n);
        cond(1'b1, 1'b0);
        xfer(9'h129);
        xfer({p, 1'b1});
        if (n) xfer({d[15:8], 1'b1});
        if (n) xfer({d[7:0], 1'b1});
        cond(1'b0, 1'b1);
    endtask
    task automatic rd(input logic [7:0] p, output logic [15:0] w);
        wr(p, 16'h0000, 1'b0);
        cond(1'b1, 1'b0);
        xfer(9'h12B);
        xfer(9'h1FE);
        xfer(9'h1FF);
        w = {r[17:10], r[8:1]};
        cond(1'b0, 1'b1);
    endtask
endmodule

// File: verif/gpd_pointer_decode_tb_top.sv
// Self-checking bench for the gamma pointer decoder.
// Assumes clock enable high; the store answers {index, 2Bh} at once.
`timescale 1ns/1ps
module gpd_pointer_decode_tb_top;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic scl, sda, oe_n, valid, inv, sdo;
    logic [3:0] na;
    logic [109:0] lvl;
    logic [7:0] gain, sw, p;
    logic [15:0] v, w, bank = 16'h0000;
    int mismatches = 0, checks_done = 0, seed = 32'h7DA0;
    initial forever #4 clock_in = ~clock_in;
    gpd_pointer_decode #(.INIT_CYCLES(20)) gpd_pointer_decode_i (.clock_in(clock_in),
        .arst_n_in(arst_n_in), .clk_en_in(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe_n_out(oe_n),
        .nv_addr_out(na), .nv_data_in({na, 6'h2B}), .bank_count_in(bank), .level_out(lvl), .gain_out(gain),
        .switch_out(sw), .inverting_out(inv), .gain_valid_out(valid));
    gpd_master_model bm (.clock_in(clock_in), .sda_oe_n_in(oe_n), .scl_out(scl), .sda_out(sda));
    task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
        checks_done++;
        mismatches += int'(s !== e);
        if (s !== e) $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #93 arst_n_in = 1'b1;
        check("gain_rst", 16'h0001, {8'h00, gain});
        check("sw_rst", 16'h0000, {8'h00, sw});
        for (int i = 0; i < 99 && valid !== 1'b1; i++) #8;
        check("valid", 16'h0001, {15'h0000, valid});
        if (valid !== 1'b1) final_report();
        bm.rd(8'h1C, w);
        check("gain_rd", 16'h8001, w);
        check("sda_drive", 16'h0000, {15'h0000, sdo});
        for (int k = 0; k < 9; k++) begin
            p = (k < 8) ? 8'h01 << k : 8'h80;
            bm.wr(8'h1C, (k < 8) ? {8'h80, p} : 16'h8003, 1'b1);
            check("gain", {8'h80, p}, {8'h80, gain});
            check("sw", {8'h00, 8'h80 >> $clog2(p)}, {8'h00, sw});
            check("inv", {15'h0000, k > 0 && k < 7}, {15'h0000, inv});
        end
        for (int i = 0; i < 13; i++) begin
            v = {6'h00, 10'($random(seed))};
            p = (i < 8) ? 8'(i) : (i == 8) ? 8'h12 : 8'(i * 3 - 19);
            bm.wr(p, v, 1'b1);
            bm.rd(p, w);
            check("level", (i < 9) ? v : 16'h0000, w);
        end
        bank = 16'($random(seed));
        bm.wr(8'h3F, ~bank, 1'b1);
        bm.rd(8'h3F, w);
        check("bank", bank, w);
        bm.wr(8'h83, 16'h0000, 1'b0);
        check("single", 16'h00EB, {6'h00, lvl[30+:10]});
        bm.wr(8'h40, 16'h0000, 1'b0);
        for (int i = 0; i < 9; i++) check("general", {6'h00, 4'(i), 6'h2B}, {6'h00, lvl[i*10+:10]});
        final_report();
    end
endmodule
